// ===== src/cfa_core.sv
// Flag register, instruction byte assembler and address unit of an 8-bit CPU.
// Assumes a sequencer that answers page and opcode combinationally with
// kind, mode and operand count, and feeds ALU operands in the execute cycle.
// Functional notes
// RULE_01: Eight-bit flag register: five result flags, two masks, stop disable.
// RULE_02: Pushes, pulls, index add-B and transfers leave all flags unchanged.
// RULE_03: Carry from carry or borrow, multiply/divide error; shifts pass through it.
// RULE_04: Overflow set on two's-complement overflow, cleared otherwise.
// RULE_05: Zero set on zero result; compares set flags, discard difference.
// RULE_06: Sixteen-bit index increment and decrement touch only zero flag.
// RULE_07: Negative equals result most significant bit.
// RULE_08: Maskable mask blocks maskable interrupts; pending ones wait.
// RULE_09: Reset sets maskable mask; only an instruction clears it.
// RULE_10: On interrupt: stack, then set maskable mask, then fetch vector.
// RULE_11: Half carry from bit three into four on add operations.
// RULE_12: Pin mask blocks pin interrupt; its acknowledge sets both masks.
// RULE_13: Pin mask set by reset or acknowledge; cleared only by flag load.
// RULE_14: Stop with stop disable set acts as no-op; reset sets it.
// RULE_15: Words stored high byte at lower address; no alignment.
// RULE_16: Four opcode pages; prebyte selects pages one to three.
// RULE_17: Optional prebyte, opcode, zero to three operands: one to five bytes.
// RULE_18: Immediate operand follows opcode, sized to its target.
// RULE_19: Direct address: operand byte low, high byte zero.
// RULE_20: Extended address from two bytes after opcode.
// RULE_21: Indexed address: unsigned offset byte plus chosen index register.
// RULE_22: Relative: taken branch adds sign-extended offset to program counter.
// RULE_23: Branch base is next instruction address; sums wrap at 64K.
`timescale 1ns/1ps
`default_nettype none
module cfa_core (
	input wire logic clk,
	input wire logic nrst,
	input wire logic byteValid,
	input wire logic [7:0] byteData,
	input wire logic [1:0] opLen,
	input wire cfa_pkg::cfa_mode_t opMode,
	input wire cfa_pkg::cfa_op_t opKind,
	input wire logic opIdxTwo,
	input wire logic [7:0] aluA,
	input wire logic [7:0] aluB,
	input wire logic branchTaken,
	input wire logic mulDivErr,
	input wire logic irqPend,
	input wire logic xirqPend,
	input wire logic stackDone,
	input wire logic stackForX,
	input wire logic vecLoad,
	input wire logic [15:0] vecData,
	input wire logic [7:0] busAddr,
	input wire logic [15:0] busWdata,
	input wire logic busWr,
	input wire logic busRd,
	output logic [15:0] busRdata,
	output logic [7:0] flags,
	output logic [1:0] page,
	output logic byteReady,
	output logic instrDone,
	output logic [2:0] instrLen,
	output logic [15:0] effAddr,
	output logic [15:0] immWord,
	output logic [7:0] aluResult,
	output logic [15:0] progCnt,
	output logic irqTake,
	output logic xirqTake,
	output logic vecFetch,
	output logic stopReq
);
	import cfa_pkg::*;
	localparam logic [7:0] ZERO_ONLY = 8'(1 << FLAG_Z);
	// ==========================================
	// State
	cfa_state_t state;
	cfa_state_t next_state;
	cfa_op_t kindQ;
	cfa_mode_t modeQ;
	logic idxTwoQ;
	logic [1:0] needQ;
	logic [1:0] gotQ;
	logic [7:0] operand [0:2];
	logic [15:0] opAddr;
	logic [2:0] lenCnt;
	logic [15:0] idx1;
	logic [15:0] idx2;
	logic pendVec;
	logic [7:0] next_flags;
	// ==========================================
	// Byte intake decode
	wire logic take = byteValid & byteReady;
	wire logic execNow = (state == ST_EXEC);
	wire logic isPre = (state == ST_FIRST) &&
		(byteData == PRE_PAGE1 || byteData == PRE_PAGE2 || byteData == PRE_PAGE3);
	wire logic [1:0] prePage = (byteData == PRE_PAGE1) ? PAGE_ONE :
		(byteData == PRE_PAGE2) ? PAGE_TWO : PAGE_THREE; // [RULE_16]
	wire logic opcodeTake = take && ((state == ST_FIRST && !isPre) || state == ST_OPCODE);
	wire logic lastOper = (state == ST_OPER) && take && (2'(gotQ + 2'h1) == needQ);
	wire logic [2:0] next_len = (state == ST_FIRST) ? LEN_MIN : 3'(lenCnt + 3'h1); // [RULE_17]
	// ==========================================
	// Sequencing; an opcode with no operands goes straight to execute
	always_comb begin
		next_state = state;
		case (state)
			ST_FIRST, ST_OPCODE: begin
				// A prebyte is only recognised as the first byte
				if (take && isPre) begin
					next_state = ST_OPCODE;
				end else if (take) begin
					next_state = (opLen == 2'h0) ? ST_EXEC : ST_OPER;
				end
			end
			ST_OPER: begin
				if (lastOper) begin
					next_state = ST_EXEC;
				end
			end
			ST_EXEC: next_state = ST_FIRST;
			default: next_state = ST_FIRST;
		endcase
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_FIRST;
			byteReady <= 1'b1;
		end else begin
			state <= next_state;
			byteReady <= (next_state != ST_EXEC); // Stall intake while executing
		end
	end
	// Page select: prebyte picks a page, execute returns to page zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			page <= PAGE_ZERO;
		end else if (take && isPre) begin
			page <= prePage; // [RULE_16]
		end else if (execNow) begin
			page <= PAGE_ZERO; // [RULE_16]
		end
	end
	// Decoded fields are latched with the opcode byte
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			kindQ <= OP_NONE;
			modeQ <= MODE_INH;
			idxTwoQ <= 1'b0;
			needQ <= 2'h0;
			opAddr <= PC_RESET;
		end else if (opcodeTake) begin
			kindQ <= opKind;
			modeQ <= opMode;
			idxTwoQ <= opIdxTwo;
			needQ <= opLen; // [RULE_17]
			opAddr <= progCnt;
		end
	end
	// Operand bytes in arrival order, no alignment assumed
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gotQ <= 2'h0;
			lenCnt <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				operand[i] <= 8'h00;
			end
		end else if (take) begin
			lenCnt <= next_len;
			if (state == ST_OPER) begin
				operand[gotQ] <= byteData; // [RULE_15]
				gotQ <= 2'(gotQ + 2'h1);
			end else begin
				gotQ <= 2'h0;
			end
		end
	end
	// ==========================================
	// Arithmetic and address helpers
	logic [7:0] aluRes;
	logic aluC;
	logic aluV;
	logic aluH;
	cfa_alu u_alu (
		.op(kindQ),
		.a(aluA),
		.b(aluB),
		.cin(flags[FLAG_C]),
		.res(aluRes),
		.c(aluC),
		.v(aluV),
		.h(aluH)
	);
	cfa_ag_if ag ();
	assign ag.mode = modeQ;
	assign ag.op0 = operand[0];
	assign ag.op1 = operand[1];
	assign ag.idx = idxTwoQ ? idx2 : idx1;
	assign ag.pcNext = progCnt; // Already past the branch [RULE_23]
	assign ag.opAddr = opAddr;
	cfa_agen u_agen (
		.ag(ag)
	);
	wire logic resN = aluRes[7];
	wire logic resZ = (aluRes == 8'h00);
	wire logic idxDec = (kindQ == OP_IDXDEC);
	wire logic [15:0] idxStep = idxDec ? 16'(ag.idx - 16'h0001) : 16'(ag.idx + 16'h0001);
	wire logic [15:0] idxAddB = 16'(ag.idx + {8'h00, aluB}); // Wraps at 64K
	wire logic idxWrite = execNow &&
		(kindQ == OP_IDXINC || kindQ == OP_IDXDEC || kindQ == OP_IDXADDB);
	wire logic [15:0] idxNew = (kindQ == OP_IDXADDB) ? idxAddB : idxStep;
	wire logic flagLoadNow = execNow && (kindQ == OP_TAP || kindQ == OP_RTI);
	// ==========================================
	// Flag update per instruction kind
	always_comb begin
		next_flags = flags;
		if (execNow) begin
			case (kindQ)
				OP_ADD, OP_ADC: begin
					next_flags[FLAG_H] = aluH; // [RULE_11]
					next_flags[FLAG_N] = resN; // [RULE_07]
					next_flags[FLAG_Z] = resZ; // [RULE_05]
					next_flags[FLAG_V] = aluV; // [RULE_04]
					next_flags[FLAG_C] = aluC; // [RULE_03]
				end
				OP_SUB, OP_CMP: begin
					next_flags[FLAG_N] = resN; // [RULE_07]
					next_flags[FLAG_Z] = resZ; // [RULE_05]
					next_flags[FLAG_V] = aluV; // [RULE_04]
					next_flags[FLAG_C] = aluC; // [RULE_03]
				end
				OP_LOGIC, OP_LOAD: begin
					next_flags[FLAG_N] = resN; // [RULE_07]
					next_flags[FLAG_Z] = resZ; // [RULE_05]
					next_flags[FLAG_V] = 1'b0; // [RULE_04]
				end
				OP_SHL, OP_SHR: begin
					next_flags[FLAG_N] = resN; // [RULE_07]
					next_flags[FLAG_Z] = resZ; // [RULE_05]
					next_flags[FLAG_C] = aluC; // [RULE_03]
					next_flags[FLAG_V] = resN ^ aluC; // [RULE_04]
				end
				OP_IDXINC, OP_IDXDEC: next_flags[FLAG_Z] = (idxStep == 16'h0000); // [RULE_06]
				OP_TAP, OP_RTI: begin
					// Software may clear the pin mask but never set it
					next_flags = aluA; // [RULE_09]
					next_flags[FLAG_X] = flags[FLAG_X] & aluA[FLAG_X]; // [RULE_13]
				end
				OP_MULDIV: next_flags[FLAG_C] = mulDivErr; // [RULE_03]
				default: next_flags = flags; // [RULE_02]
			endcase
		end
		if (stackDone) begin
			next_flags[FLAG_I] = 1'b1; // After stacking [RULE_10]
			next_flags[FLAG_X] = flags[FLAG_X] | stackForX; // [RULE_12] [RULE_13]
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flags <= FLAGS_RESET; // [RULE_01] [RULE_09] [RULE_14]
		end else begin
			flags <= next_flags;
		end
	end
	// ==========================================
	// Interrupt gating and vector fetch ordering
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irqTake <= 1'b0;
			xirqTake <= 1'b0;
			pendVec <= 1'b0;
			vecFetch <= 1'b0;
		end else begin
			irqTake <= irqPend & ~flags[FLAG_I]; // Pending waits on mask [RULE_08]
			xirqTake <= xirqPend & ~flags[FLAG_X]; // [RULE_12]
			pendVec <= stackDone; // [RULE_10]
			vecFetch <= pendVec; // One cycle after the mask is set [RULE_10]
		end
	end
	// ==========================================
	// Program counter: vector load, taken branch, byte intake
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			progCnt <= PC_RESET;
		end else if (vecLoad) begin
			progCnt <= vecData;
		end else if (execNow && modeQ == MODE_REL && branchTaken) begin
			progCnt <= ag.ea; // [RULE_22]
		end else if (take) begin
			progCnt <= 16'(progCnt + 16'h0001); // [RULE_23]
		end
	end
	// Index registers; execute wins over a bus write in the same cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			idx1 <= 16'h0000;
			idx2 <= 16'h0000;
		end else begin
			if (idxWrite && !idxTwoQ) begin
				idx1 <= idxNew; // [RULE_06]
			end else if (busWr && busAddr == REG_IDX1) begin
				idx1 <= busWdata;
			end
			if (idxWrite && idxTwoQ) begin
				idx2 <= idxNew; // [RULE_06]
			end else if (busWr && busAddr == REG_IDX2) begin
				idx2 <= busWdata;
			end
		end
	end
	// ==========================================
	// Execute results
	wire logic [15:0] immNew = (needQ == 2'h2) ? {operand[0], operand[1]} :
		{8'h00, operand[0]}; // High byte first [RULE_18] [RULE_15]
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			instrDone <= 1'b0;
			instrLen <= LEN_MIN;
			effAddr <= 16'h0000;
			immWord <= 16'h0000;
			aluResult <= 8'h00;
			stopReq <= 1'b0;
		end else begin
			instrDone <= execNow;
			stopReq <= execNow && kindQ == OP_STOP && !flags[FLAG_S]; // [RULE_14]
			if (execNow) begin
				instrLen <= lenCnt; // [RULE_17]
				effAddr <= ag.ea;
				immWord <= immNew;
				if (kindQ != OP_CMP) begin
					aluResult <= aluRes; // Compare discards [RULE_05]
				end
			end
		end
	end
	// ==========================================
	// Register port, read data valid the cycle after the strobe only
	wire logic [15:0] rdMux = (busAddr == REG_FLAGS) ? {8'h00, flags} :
		(busAddr == REG_IDX1) ? idx1 :
		(busAddr == REG_IDX2) ? idx2 :
		(busAddr == REG_PC) ? progCnt :
		(busAddr == REG_EA) ? effAddr : 16'h0000;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busRdata <= 16'h0000;
		end else begin
			busRdata <= busRd ? rdMux : 16'h0000;
		end
	end
	// ==========================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence sStacked;
		stackDone;
	endsequence
	sequence sMaskThenVector;
		flags[FLAG_I] ##1 vecFetch;
	endsequence
	a_hold_transfer: assert property ( // [RULE_02]
		execNow && (kindQ == OP_NONE || kindQ == OP_IDXADDB) && !stackDone |=> $stable(flags))
		else $error("flags changed on a transfer kind");
	a_step_zero_only: assert property ( // [RULE_06]
		execNow && (kindQ == OP_IDXINC || kindQ == OP_IDXDEC) && !stackDone |=>
		(flags & ~ZERO_ONLY) == ($past(flags) & ~ZERO_ONLY))
		else $error("index step touched a flag other than zero");
	a_int_order: assert property (sStacked |=> sMaskThenVector) // [RULE_10]
		else $error("vector fetch not after mask set");
	a_pin_masks: assert property ( // [RULE_12]
		stackDone && stackForX |=> flags[FLAG_X] && flags[FLAG_I])
		else $error("pin acknowledge did not set both masks");
	a_pin_clear_src: assert property ( // [RULE_13]
		$fell(flags[FLAG_X]) |-> $past(flagLoadNow))
		else $error("pin mask cleared without a flag load");
	a_imask_clear_src: assert property ( // [RULE_09]
		$fell(flags[FLAG_I]) |-> $past(flagLoadNow))
		else $error("maskable mask cleared without instruction");
	a_stop_as_nop: assert property ( // [RULE_14]
		execNow && kindQ == OP_STOP && flags[FLAG_S] |=> !stopReq && state == ST_FIRST)
		else $error("stop acted while disabled");
	a_irq_blocked: assert property (flags[FLAG_I] |=> !irqTake) // [RULE_08]
		else $error("maskable interrupt taken while masked");
	a_direct_high: assert property ( // [RULE_19]
		instrDone && modeQ == MODE_DIR |-> effAddr[15:8] == DIRECT_PAGE_HI)
		else $error("direct address high byte not zero");
	a_len_range: assert property ( // [RULE_17]
		instrDone |-> instrLen >= LEN_MIN && instrLen <= LEN_MAX)
		else $error("instruction length out of range");
	a_load_nz: assert property ( // [RULE_05]
		execNow && kindQ == OP_LOAD && !stackDone |=>
		flags[FLAG_Z] == (aluResult == 8'h00) && flags[FLAG_N] == aluResult[7])
		else $error("load flags do not match result");
	a_prebyte_page: assert property ( // [RULE_16]
		take && isPre |=> page != PAGE_ZERO)
		else $error("prebyte did not select a page");
endmodule : cfa_core
`default_nettype wire

// ===== pkg/cfa_pkg.sv
// Constants, types and the register map of the flag and address unit.
// Assumes a sequencer that decodes page and opcode into kind, mode, length.
package cfa_pkg;
	// ==========================================
	// Flag register layout and reset
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_V = 1;
	localparam int unsigned FLAG_Z = 2;
	localparam int unsigned FLAG_N = 3;
	localparam int unsigned FLAG_I = 4;
	localparam int unsigned FLAG_H = 5;
	localparam int unsigned FLAG_X = 6;
	localparam int unsigned FLAG_S = 7;
	localparam logic [7:0] FLAGS_RESET = 8'hd0; // S, X and I set
	// ==========================================
	// Opcode paging, prebyte values are plain defaults
	localparam logic [7:0] PRE_PAGE1 = 8'h18;
	localparam logic [7:0] PRE_PAGE2 = 8'h1a;
	localparam logic [7:0] PRE_PAGE3 = 8'hcd;
	localparam logic [1:0] PAGE_ZERO = 2'h0;
	localparam logic [1:0] PAGE_ONE = 2'h1;
	localparam logic [1:0] PAGE_TWO = 2'h2;
	localparam logic [1:0] PAGE_THREE = 2'h3;
	localparam logic [2:0] LEN_MIN = 3'h1;
	localparam logic [2:0] LEN_MAX = 3'h5;
	localparam logic [7:0] DIRECT_PAGE_HI = 8'h00;
	localparam logic [15:0] PC_RESET = 16'h0000;
	// ==========================================
	// Register map, byte addresses
	localparam logic [7:0] REG_FLAGS = 8'h00;
	localparam logic [7:0] REG_IDX1 = 8'h04;
	localparam logic [7:0] REG_IDX2 = 8'h08;
	localparam logic [7:0] REG_PC = 8'h0c;
	localparam logic [7:0] REG_EA = 8'h10;
	// ==========================================
	// Types
	typedef enum logic [2:0] {MODE_INH, MODE_IMM, MODE_DIR, MODE_EXT, MODE_IDX,
		MODE_REL} cfa_mode_t;
	typedef enum logic [4:0] {OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_CMP, OP_LOGIC,
		OP_LOAD, OP_SHL, OP_SHR, OP_IDXINC, OP_IDXDEC, OP_IDXADDB, OP_TAP,
		OP_RTI, OP_MULDIV, OP_STOP} cfa_op_t;
	typedef enum logic [1:0] {ST_FIRST, ST_OPCODE, ST_OPER, ST_EXEC} cfa_state_t;
endpackage : cfa_pkg

// ===== pkg/cfa_ag_if.sv
// Interface between the sequencing core and the address generator.
// Assumes both ends run combinationally within one clock.
`timescale 1ns/1ps
`default_nettype none
interface cfa_ag_if;
	import cfa_pkg::*;
	cfa_mode_t mode;
	logic [7:0] op0;
	logic [7:0] op1;
	logic [15:0] idx;
	logic [15:0] pcNext;
	logic [15:0] opAddr;
	logic [15:0] ea;
	modport core (output mode, op0, op1, idx, pcNext, opAddr, input ea);
	modport agen (input mode, op0, op1, idx, pcNext, opAddr, output ea);
endinterface : cfa_ag_if
`default_nettype wire

// ===== src/cfa_agen.sv
// Effective address generator, purely combinational.
// Assumes the core holds operands steady through the execute cycle.
`timescale 1ns/1ps
`default_nettype none
module cfa_agen (
	cfa_ag_if.agen ag
);
	import cfa_pkg::*;
	// ==========================================
	// Address sums, all 16 bits wide so they wrap in the 64K space
	wire logic [15:0] eaImm = 16'(ag.opAddr + 16'h0001); // [RULE_18] [RULE_23]
	wire logic [15:0] eaDir = {DIRECT_PAGE_HI, ag.op0}; // [RULE_19]
	wire logic [15:0] eaExt = {ag.op0, ag.op1}; // High byte first [RULE_20] [RULE_15]
	wire logic [15:0] eaIdx = 16'(ag.idx + {8'h00, ag.op0}); // [RULE_21] [RULE_23]
	wire logic [15:0] eaRel = 16'(ag.pcNext + {{8{ag.op0[7]}}, ag.op0}); // [RULE_22] [RULE_23]
	// Mode select; inherent has no address
	assign ag.ea = (ag.mode == MODE_IMM) ? eaImm :
		(ag.mode == MODE_DIR) ? eaDir :
		(ag.mode == MODE_EXT) ? eaExt :
		(ag.mode == MODE_IDX) ? eaIdx :
		(ag.mode == MODE_REL) ? eaRel : 16'h0000;
endmodule : cfa_agen
`default_nettype wire

// ===== src/cfa_alu.sv
// Eight-bit arithmetic unit with carry, overflow and half carry out.
// Assumes the core derives zero and negative from the result.
`timescale 1ns/1ps
`default_nettype none
module cfa_alu (
	input wire cfa_pkg::cfa_op_t op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	output logic [7:0] res,
	output logic c,
	output logic v,
	output logic h
);
	import cfa_pkg::*;
	// ==========================================
	// Adder and subtractor share nothing; clarity over area
	wire logic addCin = (op == OP_ADC) & cin;
	wire logic [8:0] sum = 9'({1'b0, a} + {1'b0, b} + {8'h00, addCin});
	wire logic [8:0] diff = 9'({1'b0, a} - {1'b0, b});
	always_comb begin
		res = a;
		c = cin;
		v = 1'b0;
		h = 1'b0;
		case (op)
			OP_ADD, OP_ADC: begin
				res = sum[7:0];
				c = sum[8]; // [RULE_03]
				v = (a[7] & b[7] & ~sum[7]) | (~a[7] & ~b[7] & sum[7]); // [RULE_04]
				h = a[4] ^ b[4] ^ sum[4]; // Carry into bit 4 [RULE_11]
			end
			OP_SUB, OP_CMP: begin
				res = diff[7:0];
				c = diff[8]; // Borrow [RULE_03]
				v = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]); // [RULE_04]
			end
			OP_LOGIC: res = a & b;
			OP_LOAD: res = b;
			OP_SHL: begin
				res = {a[6:0], cin}; // Through carry [RULE_03]
				c = a[7];
			end
			OP_SHR: begin
				res = {cin, a[7:1]}; // [RULE_03]
				c = a[0];
			end
			default: res = a;
		endcase
	end
endmodule : cfa_alu
`default_nettype wire

// ===== bench/cfa_feed.sv
// Instruction byte source: program memory plus opcode decode, queue fed.
// Assumes bytes are taken at an edge where offer and ready are both high.
`timescale 1ns/1ps
`default_nettype none
module cfa_feed (
	input wire logic clk,
	input wire logic nrst,
	input wire logic byteReady,
	output logic byteValid,
	output logic [7:0] byteData,
	output logic [1:0] opLen,
	output var cfa_pkg::cfa_mode_t opMode,
	output var cfa_pkg::cfa_op_t opKind,
	output logic opIdxTwo
);
	import cfa_pkg::*;
	logic [18:0] q[$];
	// ==========================================
	// Offer queue head in order; a released data line toggles so stale bytes look wrong
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			byteValid <= 1'b0;
			byteData <= 8'h00;
		end else begin
			if (byteValid && byteReady) begin
				void'(q.pop_front());
			end
			if (q.size() > 0) begin
				// Enum fields are cast one by one; a packed unpack into them is illegal
				byteValid <= 1'b1;
				opIdxTwo <= q[0][18];
				opKind <= cfa_op_t'(q[0][17:13]);
				opMode <= cfa_mode_t'(q[0][12:10]);
				opLen <= q[0][9:8];
				byteData <= q[0][7:0];
			end else begin
				byteValid <= 1'b0;
				byteData <= ~byteData;
			end
		end
	end
endmodule : cfa_feed
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench of the flag and address unit, random and corner cases.
// Assumes the byte source model answers the core's intake handshake.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import cfa_pkg::*;
	logic clk, nrst, byteValid, byteReady, opIdxTwo, branchTaken, mulDivErr, irqPend, xirqPend;
	logic stackDone, stackForX, vecLoad, busWr, busRd, instrDone, irqTake, xirqTake, vecFetch;
	logic stopReq, stopSeen;
	logic [1:0] opLen, page, pageSeen, pg;
	logic [2:0] instrLen;
	logic [7:0] byteData, aluA, aluB, busAddr, flags, aluResult, expRes;
	logic [7:0] expFlags = FLAGS_RESET;
	logic [15:0] vecData, busWdata, busRdata, effAddr, immWord, progCnt, ex;
	logic [15:0] expPc = PC_RESET;
	logic [15:0] idxVal [2] = '{16'h0000, 16'h0000};
	logic [31:0] seed = 32'h3affb36a;
	logic [31:0] r;
	logic [7:0] preByte [4] = '{8'h00, PRE_PAGE1, PRE_PAGE2, PRE_PAGE3};
	logic [7:0] flagLoad [3] = '{8'h00, 8'hff, 8'h00};
	cfa_op_t aluKind [6] = '{OP_ADD, OP_ADC, OP_SUB, OP_CMP, OP_LOGIC, OP_LOAD};
	cfa_mode_t opMode;
	cfa_op_t opKind, k;
	int badCount = 0;
	int nTests = 0;
	int i;
	cfa_core u_cfa_core (.*);
	cfa_feed u_cfa_feed (.*);
	// ==========================================
	// Clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Hang guard, far above the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		badCount++;
		conclude();
	end
	// ==========================================
	// Helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic logic [15:0] aluExp(cfa_op_t o, logic [7:0] a, logic [7:0] b, logic [7:0] f);
		logic [8:0] s;
		logic [7:0] g;
		logic ci;
		g = f;
		ci = (o == OP_ADC) && f[FLAG_C];
		case (o)
			OP_ADD, OP_ADC: begin
				s = {1'b0, a} + {1'b0, b} + 9'(ci);
				g[FLAG_H] = (5'(a[3:0]) + 5'(b[3:0]) + 5'(ci)) > 5'h0f;
				g[FLAG_V] = (a[7] == b[7]) && (s[7] != a[7]);
				g[FLAG_C] = s[8];
			end
			OP_SUB, OP_CMP: begin
				s = {1'b0, a} - {1'b0, b};
				g[FLAG_V] = (a[7] != b[7]) && (s[7] != a[7]);
				g[FLAG_C] = s[8];
			end
			default: begin
				s = (o == OP_LOGIC) ? {1'b0, a & b} : {1'b0, b};
				g[FLAG_V] = 1'b0;
			end
		endcase
		g[FLAG_N] = s[7];
		g[FLAG_Z] = s[7:0] == 8'h00;
		return {s[7:0], g};
	endfunction : aluExp
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		nTests++;
		if (s !== e) begin
			badCount++;
			$display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic conclude();
		if (badCount == 0 && nTests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		busAddr <= a;
		busWdata <= d;
		busWr <= 1'b1;
		@(posedge clk);
		busWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		busAddr <= a;
		busRd <= 1'b1;
		@(posedge clk);
		busRd <= 1'b0;
		@(negedge clk);
		chk(busRdata, e);
	endtask : rd
	// One instruction through the intake, then every result it names
	task automatic run(input logic [7:0] pre, input logic [1:0] n, input cfa_mode_t m,
		input cfa_op_t o, input logic i2, input logic [23:0] op);
		logic [15:0] base;
		logic [2:0] len;
		int t;
		base = expPc + 16'(pre != 8'h00);
		len = 3'(n) + 3'h1 + 3'(pre != 8'h00);
		pg = (pre == PRE_PAGE1) ? PAGE_ONE : (pre == PRE_PAGE2) ? PAGE_TWO :
			(pre == PRE_PAGE3) ? PAGE_THREE : PAGE_ZERO;
		if (pre != 8'h00) begin
			u_cfa_feed.q.push_back({i2, o, m, n, pre});
		end
		u_cfa_feed.q.push_back({i2, o, m, n, 8'h5a});
		for (t = 0; t < n; t++) begin
			u_cfa_feed.q.push_back({i2, o, m, n, op[23 - 8 * t -: 8]});
		end
		{stopSeen, pageSeen, t} = 0;
		do begin
			@(negedge clk);
			stopSeen |= stopReq;
			pageSeen |= page;
			t++;
		end while (instrDone !== 1'b1 && t < 40);
		chk(16'(instrDone), 16'h1);
		expPc = expPc + 16'(len);
		if (m == MODE_REL && branchTaken) begin
			expPc = expPc + {{8{op[23]}}, op[23:16]};
		end
		chk(16'(instrLen), 16'(len));
		chk(16'(pageSeen), 16'(pg));
		chk(progCnt, expPc);
		chk(16'(flags), 16'(expFlags));
		case (m)
			MODE_DIR: chk(effAddr, {DIRECT_PAGE_HI, op[23:16]});
			MODE_EXT: chk(effAddr, op[23:8]);
			MODE_IDX: chk(effAddr, idxVal[i2] + {8'h00, op[23:16]});
			MODE_IMM: begin
				chk(effAddr, base + 16'h0001);
				chk(immWord, n == 2'h2 ? op[23:8] : {8'h00, op[23:16]});
			end
			default: ;
		endcase
	endtask : run
	// ==========================================
	// Main sequence
	initial begin
		{nrst, irqPend, xirqPend, stackDone, stackForX, vecLoad, busWr, busRd} = 8'h00;
		{aluA, aluB, busAddr, busWdata, vecData, branchTaken, mulDivErr} = 58'h0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		chk(16'(flags), 16'(FLAGS_RESET));
		run(8'h00, 2'h0, MODE_INH, OP_STOP, 1'b0, 24'h0);
		chk(16'(stopSeen), 16'h0);
		// Register port, read-only and unmapped places, index step wrap
		wr(REG_IDX1, 16'hffff);
		wr(REG_FLAGS, 16'h0000);
		rd(REG_FLAGS, 16'(FLAGS_RESET));
		rd(8'h14, 16'h0000);
		expFlags = FLAGS_RESET | 8'h04;
		run(8'h00, 2'h0, MODE_INH, OP_IDXINC, 1'b0, 24'h0);
		rd(REG_IDX1, 16'h0000);
		expFlags = FLAGS_RESET;
		run(8'h00, 2'h0, MODE_INH, OP_IDXDEC, 1'b1, 24'h0);
		rd(REG_IDX2, 16'hffff);
		@(posedge clk);
		aluB <= 8'h80;
		run(8'h00, 2'h0, MODE_INH, OP_IDXADDB, 1'b0, 24'h0);
		rd(REG_IDX1, 16'h0080);
		idxVal = '{16'h0080, 16'hffff};
		// Flag loads: the pin mask may be cleared but never set this way
		for (i = 0; i < 3; i++) begin
			@(posedge clk);
			aluA <= flagLoad[i];
			expFlags = flagLoad[i] & (expFlags | 8'hbf);
			run(8'h00, 2'h0, MODE_INH, i == 2 ? OP_RTI : OP_TAP, 1'b0, 24'h0);
		end
		run(8'h00, 2'h0, MODE_INH, OP_STOP, 1'b0, 24'h0);
		chk(16'(stopSeen), 16'h1);
		// Interrupt entry: masks set after stacking, vector fetch after that
		@(posedge clk);
		{irqPend, xirqPend} <= 2'h3;
		repeat (3) @(negedge clk);
		chk(16'({irqTake, xirqTake}), 16'h0003);
		@(posedge clk);
		{stackDone, stackForX} <= 2'h3;
		@(posedge clk);
		{stackDone, stackForX} <= 2'h0;
		@(negedge clk);
		chk(16'({flags[FLAG_X], flags[FLAG_I], vecFetch}), 16'h0006);
		@(negedge clk);
		chk(16'(vecFetch), 16'h0001);
		@(negedge clk);
		chk(16'({irqTake, xirqTake}), 16'h0000);
		@(posedge clk);
		{irqPend, xirqPend, vecLoad, mulDivErr} <= 4'h3;
		vecData <= 16'h8000;
		@(posedge clk);
		vecLoad <= 1'b0;
		{expPc, expFlags} = {16'h8000, 8'h51};
		run(8'h00, 2'h0, MODE_INH, OP_MULDIV, 1'b0, 24'h0);
		// Random arithmetic with overflow and carry corners first
		for (i = 0; i < 30; i++) begin
			r = (i < 2) ? {16'h0001, i == 0 ? 8'h7f : 8'hff, 8'h00} : xs();
			k = (i < 2) ? OP_ADD : aluKind[r % 6];
			@(posedge clk);
			aluA <= r[15:8];
			aluB <= r[23:16];
			ex = aluExp(k, r[15:8], r[23:16], expFlags);
			expFlags = ex[7:0];
			expRes = (k == OP_CMP) ? expRes : ex[15:8];
			run(8'h00, 2'h0, MODE_INH, k, 1'b0, 24'h0);
			chk(16'(aluResult), 16'(expRes));
		end
		// Address modes over all pages, wrap and both branch outcomes
		for (i = 0; i < 4; i++) begin
			r = xs();
			run(preByte[i], i == 3 ? 2'h3 : 2'h2, MODE_EXT, OP_NONE, 1'b0, r[23:0]);
		end
		run(8'h00, 2'h1, MODE_DIR, OP_NONE, 1'b0, r[23:0]);
		run(8'h00, 2'h2, MODE_IMM, OP_NONE, 1'b0, r[31:8]);
		run(PRE_PAGE2, 2'h1, MODE_IMM, OP_NONE, 1'b0, r[23:0]);
		run(8'h00, 2'h1, MODE_IDX, OP_NONE, 1'b1, {8'hff, r[15:0]});
		run(8'h00, 2'h1, MODE_IDX, OP_NONE, 1'b0, r[23:0]);
		for (i = 0; i < 3; i++) begin
			@(posedge clk);
			branchTaken <= (i != 1);
			run(8'h00, 2'h1, MODE_REL, OP_NONE, 1'b0, {i == 0 ? 8'h80 : r[7:0], 16'h0});
		end
		conclude();
	end
endmodule : tb
`default_nettype wire
